// File: dv/sample_fifo_32_tb.sv
// sample_fifo_32_tb: self-checking bench for the sample fifo
// assumes: host model on the link port, samples driven from ref_clk
`timescale 1ns/10ps

module sample_fifo_32_tb;
  import sfifo_pkg::*;
  logic ref_clk, link_clk, reset_n, sample_valid, trigger_event, active_mode, auto_sleep;
  logic [13:0] sample_x, sample_y, sample_z;
  sfifo_byte_t normal_status, lk_addr, lk_wdata, lk_rdata, fifo_setup, rd;
  logic lk_req, lk_write, lk_ack, buffer_irq_status, gate_error_clear;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_gclr = 0;

  sfifo_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk),
    .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
    .sample_z(sample_z), .trigger_event(trigger_event), .active_mode(active_mode),
    .auto_sleep(auto_sleep), .normal_status(normal_status), .lk_req(lk_req),
    .lk_write(lk_write), .lk_addr(lk_addr), .lk_wdata(lk_wdata), .lk_ack(lk_ack),
    .lk_rdata(lk_rdata), .buffer_irq_status(buffer_irq_status),
    .gate_error_clear(gate_error_clear), .fifo_setup(fifo_setup));

  sfifo_host host (.link_clk(link_clk), .lk_ack(lk_ack), .lk_rdata(lk_rdata),
    .lk_req(lk_req), .lk_write(lk_write), .lk_addr(lk_addr), .lk_wdata(lk_wdata));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  // gate error clear pulses, counted away from the launching edge
  always @(negedge ref_clk) begin
    if (gate_error_clear === 1'b1) begin
      n_gclr++;
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      results();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task rd_reg(input sfifo_byte_t a, input sfifo_byte_t exp);
    host.xfer(1'b0, a, 8'h00, rd);
    chk(rd, exp);
  endtask

  task wr_reg(input sfifo_byte_t a, input sfifo_byte_t d);
    host.xfer(1'b1, a, d, rd);
  endtask

  function automatic logic [13:0] smp(input int i, input int k);
    return 14'(i * 65 + 3 + k * 300);
  endfunction

  function automatic sfifo_byte_t sbyte(input int i, input int k);
    logic [13:0] v;
    v = smp(i, k / 2);
    return (k % 2) ? {v[5:0], 2'b00} : v[13:6];
  endfunction

  task push(input int first, input int n);
    for (int j = 0; j < n; j++) begin
      @(posedge ref_clk);
      #2;
      sample_valid = 1'b1;
      sample_x = smp(first + j, 0);
      sample_y = smp(first + j, 1);
      sample_z = smp(first + j, 2);
    end
    @(posedge ref_clk);
    #2;
    sample_valid = 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task head(input int i);
    for (int k = 0; k < 6; k++) begin
      rd_reg(8'h01 + 8'(k), sbyte(i, k));
    end
  endtask

  task t_reset;
    chk(fifo_setup, 8'h00);
    rd_reg(8'h09, 8'h00);
    rd_reg(8'h00, 8'h5a);
    rd_reg(8'h0f, 8'h00);
  endtask

  task t_circ_wm;
    active_mode = 1'b0;
    wr_reg(8'h09, 8'h44);
    rd_reg(8'h09, 8'h44);
    @(posedge ref_clk);
    #2;
    active_mode = 1'b1;
    push(0, 5);
    chk({7'h00, buffer_irq_status}, 8'h01);
    rd_reg(8'h00, 8'h45);
    repeat (10) @(posedge ref_clk);
    chk({7'h00, buffer_irq_status}, 8'h00);
    push(5, 1);
    chk({7'h00, buffer_irq_status}, 8'h01);
    host.gap = 3;
    head(0);
    rd_reg(8'h00, 8'h45);
    head(1);
    rd_reg(8'h00, 8'h44);
    head(2);
    rd_reg(8'h00, 8'h03);
    host.gap = 0;
  endtask

  task t_fill;
    wr_reg(8'h09, 8'h00);
    rd_reg(8'h00, 8'h5a);
    wr_reg(8'h09, 8'h87);
    rd_reg(8'h09, 8'h84);
    chk(fifo_setup, 8'h84);
    push(10, 33);
    rd_reg(8'h00, 8'he0);
    head(10);
    rd_reg(8'h00, 8'h5f);
  endtask

  task t_circ_ovf;
    wr_reg(8'h09, 8'h00);
    wr_reg(8'h09, 8'h44);
    rd_reg(8'h00, 8'h00);
    push(50, 33);
    rd_reg(8'h00, 8'he0);
    head(51);
  endtask

  task t_trig;
    wr_reg(8'h09, 8'h00);
    wr_reg(8'h09, 8'hc4);
    push(100, 10);
    rd_reg(8'h00, 8'h04);
    @(posedge ref_clk);
    #2;
    trigger_event = 1'b1;
    @(posedge ref_clk);
    #2;
    trigger_event = 1'b0;
    push(110, 40);
    rd_reg(8'h00, 8'he0);
    head(106);
  endtask

  task t_flush;
    wr_reg(8'h09, 8'h00);
    wr_reg(8'h09, 8'h44);
    push(200, 3);
    rd_reg(8'h00, 8'h03);
    @(posedge ref_clk);
    #2;
    auto_sleep = 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_reg(8'h00, 8'h00);
    push(210, 2);
    rd_reg(8'h00, 8'h02);
    chk(8'(n_gclr), 8'h00);
    head(210);
    chk(8'(n_gclr), 8'h00);
    head(211);
    chk(8'(n_gclr), 8'h01);
    rd_reg(8'h00, 8'h00);
    wr_reg(8'h09, 8'h00);
    rd_reg(8'h00, 8'h5a);
    rd_reg(8'h01, sbyte(211, 0));
  endtask

  task results;
    num_errors += int'(host.hang === 1'b1);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    sample_valid = 1'b0;
    trigger_event = 1'b0;
    active_mode = 1'b0;
    auto_sleep = 1'b0;
    sample_x = 14'h0000;
    sample_y = 14'h0000;
    sample_z = 14'h0000;
    normal_status = 8'h5a;
    repeat (20) @(posedge ref_clk);
    #2;
    reset_n = 1'b1;
    repeat (20) @(posedge ref_clk);
    t_reset();
    t_circ_wm();
    t_fill();
    t_circ_ovf();
    t_trig();
    t_flush();
    results();
  end
endmodule // sample_fifo_32_tb

// File: dv/sfifo_host.sv
// sfifo_host: host model issuing register transfers on the link port
// assumes: link_clk from the bench, design answers with a one-cycle lk_ack
`timescale 1ns/10ps

module sfifo_host (
  input wire logic link_clk,
  input wire logic lk_ack,
  input wire sfifo_pkg::sfifo_byte_t lk_rdata,
  output logic lk_req,
  output logic lk_write,
  output sfifo_pkg::sfifo_byte_t lk_addr,
  output sfifo_pkg::sfifo_byte_t lk_wdata
);
  import sfifo_pkg::*;
  logic hang;
  int gap;

  initial begin
    lk_req = 1'b0;
    lk_write = 1'b0;
    lk_addr = 8'h00;
    lk_wdata = 8'h00;
    hang = 1'b0;
    gap = 0;
  end

  task automatic xfer(input logic wr, input sfifo_byte_t a, input sfifo_byte_t d,
                      output sfifo_byte_t q);
    int n;
    n = 0;
    repeat (gap) @(posedge link_clk);
    @(posedge link_clk);
    #2;
    lk_req = 1'b1;
    lk_write = wr;
    lk_addr = a;
    lk_wdata = d;
    @(posedge link_clk);
    #2;
    lk_req = 1'b0;
    // released lines show the inverse of the last value
    lk_addr = ~a;
    lk_wdata = ~d;
    do begin
      @(posedge link_clk);
      #1;
      n++;
    end while (lk_ack !== 1'b1 && n < 20);
    if (lk_ack !== 1'b1) hang = 1'b1;
    q = lk_rdata;
  endtask
endmodule // sfifo_host

// File: verilog/sfifo_params.svh
// sfifo_params.svh: register offsets, field positions, reset values and sizes
// assumes: included by the sample fifo design file by bare name
`ifndef SFIFO_PARAMS_SVH
`define SFIFO_PARAMS_SVH

`define SFIFO_ADDR_STATUS 8'h00
`define SFIFO_ADDR_X_MSB 8'h01
`define SFIFO_ADDR_X_LSB 8'h02
`define SFIFO_ADDR_Y_MSB 8'h03
`define SFIFO_ADDR_Y_LSB 8'h04
`define SFIFO_ADDR_Z_MSB 8'h05
`define SFIFO_ADDR_Z_LSB 8'h06
`define SFIFO_ADDR_SETUP 8'h09

`define SFIFO_STAT_OVF_BIT 7
`define SFIFO_STAT_WM_BIT 6
`define SFIFO_SETUP_MODE_HI 7
`define SFIFO_SETUP_MODE_LO 6
`define SFIFO_SETUP_WM_HI 5
`define SFIFO_SETUP_WM_LO 0

`define SFIFO_SETUP_RESET 8'h00
`define SFIFO_DEPTH 6'h20
`define SFIFO_AXIS_W 14

`endif

// File: verilog/sfifo_pkg.sv
// sfifo_pkg: types shared by the sample fifo design
// assumes: nothing beyond the params header
package sfifo_pkg;
  typedef enum logic [1:0] {
    SFIFO_OFF = 2'b00,
    SFIFO_CIRC = 2'b01,
    SFIFO_FILL = 2'b10,
    SFIFO_TRIG = 2'b11
  } sfifo_mode_e;
  typedef logic [5:0] sfifo_cnt_t;
  typedef logic [7:0] sfifo_byte_t;
endpackage

// File: verilog/sfifo_top.sv
// sfifo_top: 32-entry three-axis sample fifo with status and setup registers
// assumes: register requests arrive on link_clk from a serial register slave,
// samples, trigger and mode levels come from logic on ref_clk
//
// Contract
// - status register appears at address 0x00 while mode is nonzero
// - status holds overflow bit 7, watermark bit 6, count bits 5..0
// - count reports 0 to 32 stored samples
// - overflow flag sets on a push into a full buffer and holds while the buffer stays full
// - watermark flag holds while count is at or above watermark
// - watermark value zero disables the watermark flag outside mode 11
// - status read clears fifo interrupt bit; next stored sample re-sets it while a flag is set
// - mode 00 disables and clears flags and count
// - mode 01 discards oldest sample on overflow
// - mode 10 stops accepting samples once overflowed
// - mode 11 keeps watermark pre-trigger samples, then 32 minus watermark
// - in mode 11 watermark flag means trigger seen
// - in mode 11 overflow stays 0 before trigger, set means stopped
// - flush on disable, sleep/wake rate change, standby to active
// - mode writable when active; watermark only in standby
// - count above watermark does not block new samples
// - one sample per active output-rate period
// - reading the buffer returns and removes the oldest sample
// - setup register: mode bits 7..6, watermark bits 5..0, reset zero
// - data address 0x01 reads buffer head while enabled
// - emptying the buffer clears the gate error bit; gate_error_clear pulses only when a read empties it, not on a flush
`timescale 1ns/10ps
`include "sfifo_params.svh"

module sfifo_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic sample_valid,
  input wire logic [13:0] sample_x,
  input wire logic [13:0] sample_y,
  input wire logic [13:0] sample_z,
  input wire logic trigger_event,
  input wire logic active_mode,
  input wire logic auto_sleep,
  input wire sfifo_pkg::sfifo_byte_t normal_status,
  input wire logic lk_req,
  input wire logic lk_write,
  input wire sfifo_pkg::sfifo_byte_t lk_addr,
  input wire sfifo_pkg::sfifo_byte_t lk_wdata,
  output logic lk_ack,
  output sfifo_pkg::sfifo_byte_t lk_rdata,
  output logic buffer_irq_status,
  output logic gate_error_clear,
  output sfifo_pkg::sfifo_byte_t fifo_setup
);
  import sfifo_pkg::*;

  logic [1:0] rst_sync_ff;
  logic [1:0] lrst_sync_ff;
  logic rst_n;
  logic lrst_n;

  // link side
  logic lk_busy_ff;
  logic lk_req_tgl_ff;
  logic lk_write_ff;
  sfifo_byte_t lk_addr_ff;
  sfifo_byte_t lk_wdata_ff;
  logic [2:0] ack_sync_ff;
  logic ack_lvl_ff;
  logic ack_ev;
  logic lk_ack_ff;
  sfifo_byte_t lk_rdata_ff;

  // core side
  logic [2:0] req_sync_ff;
  logic req_lvl_ff;
  logic req_ev;
  logic ack_tgl_ff;
  sfifo_byte_t rd_ref_ff;
  sfifo_byte_t read_mux;
  sfifo_mode_e mode_ff;
  sfifo_cnt_t wmrk_ff;
  logic [41:0] mem_ff [0:31];
  logic [41:0] cur_ff;
  logic [41:0] head;
  logic [4:0] wr_ptr_ff;
  logic [4:0] rd_ptr_ff;
  sfifo_cnt_t cnt_ff;
  sfifo_cnt_t post_cnt_ff;
  logic trig_ff;
  logic ovf_ff;
  logic wm_ff;
  logic active_q_ff;
  logic sleep_q_ff;
  logic flag_q_ff;
  logic irq_ff;
  logic gclr_ff;
  logic enabled;
  logic full;
  logic flush;
  logic pre_lim;
  logic post_done;
  logic push;
  logic write_en;
  logic pop;
  logic drop;
  logic rd_adv;
  logic status_rd;
  logic ovf_evt;
  logic nxt_wm;

  // reset release, one copy per domain
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lrst_sync_ff <= 2'b00;
    end else begin
      lrst_sync_ff <= {lrst_sync_ff[0], 1'b1};
    end
  end
  assign lrst_n = lrst_sync_ff[1];

  // link request capture and answer return
  // one request in flight
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lk_busy_ff <= 1'b0;
      lk_req_tgl_ff <= 1'b0;
      lk_write_ff <= 1'b0;
      lk_addr_ff <= 8'h00;
      lk_wdata_ff <= 8'h00;
      lk_ack_ff <= 1'b0;
      lk_rdata_ff <= 8'h00;
    end else begin
      lk_ack_ff <= 1'b0;
      if (ack_ev) begin
        lk_busy_ff <= 1'b0;
        lk_ack_ff <= 1'b1;
        lk_rdata_ff <= rd_ref_ff;
      end else if (lk_req && !lk_busy_ff) begin
        lk_busy_ff <= 1'b1;
        lk_req_tgl_ff <= ~lk_req_tgl_ff;
        lk_write_ff <= lk_write;
        lk_addr_ff <= lk_addr;
        lk_wdata_ff <= lk_wdata;
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ack_sync_ff <= 3'h0;
      ack_lvl_ff <= 1'b0;
    end else begin
      ack_sync_ff <= {ack_sync_ff[1:0], ack_tgl_ff};
      if (ack_sync_ff[1] == ack_sync_ff[2]) begin
        ack_lvl_ff <= ack_sync_ff[2];
      end
    end
  end
  assign ack_ev = (ack_sync_ff[1] == ack_sync_ff[2]) && (ack_sync_ff[2] != ack_lvl_ff);

  // request toggle into the core domain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync_ff <= 3'h0;
      req_lvl_ff <= 1'b0;
    end else begin
      req_sync_ff <= {req_sync_ff[1:0], lk_req_tgl_ff};
      if (req_sync_ff[1] == req_sync_ff[2]) begin
        req_lvl_ff <= req_sync_ff[2];
      end
    end
  end
  assign req_ev = (req_sync_ff[1] == req_sync_ff[2]) && (req_sync_ff[2] != req_lvl_ff);

  assign enabled = (mode_ff != SFIFO_OFF);
  assign full = (cnt_ff == `SFIFO_DEPTH);
  assign head = mem_ff[rd_ptr_ff];
  assign status_rd = req_ev && !lk_write_ff && (lk_addr_ff == `SFIFO_ADDR_STATUS) && enabled;
  // pop after the last byte of a sample
  assign pop = req_ev && !lk_write_ff && (lk_addr_ff == `SFIFO_ADDR_Z_LSB) && enabled
    && (cnt_ff != 6'h00);

  // register read selection
  // status replaces normal status
  always_comb begin
    read_mux = 8'h00;
    if (lk_addr_ff == `SFIFO_ADDR_STATUS) begin
      read_mux = enabled ? {ovf_ff, wm_ff, cnt_ff} : normal_status;
    end else if (lk_addr_ff == `SFIFO_ADDR_X_MSB) begin
      read_mux = enabled ? head[41:34] : cur_ff[41:34];
    end else if (lk_addr_ff == `SFIFO_ADDR_X_LSB) begin
      read_mux = enabled ? {head[33:28], 2'b00} : {cur_ff[33:28], 2'b00};
    end else if (lk_addr_ff == `SFIFO_ADDR_Y_MSB) begin
      read_mux = enabled ? head[27:20] : cur_ff[27:20];
    end else if (lk_addr_ff == `SFIFO_ADDR_Y_LSB) begin
      read_mux = enabled ? {head[19:14], 2'b00} : {cur_ff[19:14], 2'b00};
    end else if (lk_addr_ff == `SFIFO_ADDR_Z_MSB) begin
      read_mux = enabled ? head[13:6] : cur_ff[13:6];
    end else if (lk_addr_ff == `SFIFO_ADDR_Z_LSB) begin
      read_mux = enabled ? {head[5:0], 2'b00} : {cur_ff[5:0], 2'b00};
    end else if (lk_addr_ff == `SFIFO_ADDR_SETUP) begin
      read_mux = {mode_ff, wmrk_ff};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ref_ff <= 8'h00;
      ack_tgl_ff <= 1'b0;
    end else if (req_ev) begin
      rd_ref_ff <= read_mux;
      ack_tgl_ff <= ~ack_tgl_ff;
    end
  end

  // setup register
  // setup fields and reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= SFIFO_OFF;
      wmrk_ff <= 6'(`SFIFO_SETUP_RESET);
    end else if (req_ev && lk_write_ff && (lk_addr_ff == `SFIFO_ADDR_SETUP)) begin
      mode_ff <= sfifo_mode_e'(lk_wdata_ff[`SFIFO_SETUP_MODE_HI:`SFIFO_SETUP_MODE_LO]);
      if (!active_mode) begin
        wmrk_ff <= lk_wdata_ff[`SFIFO_SETUP_WM_HI:`SFIFO_SETUP_WM_LO];
      end
    end
  end
  assign fifo_setup = {mode_ff, wmrk_ff};

  // flush sources
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q_ff <= 1'b0;
      sleep_q_ff <= 1'b0;
    end else begin
      active_q_ff <= active_mode;
      sleep_q_ff <= auto_sleep;
    end
  end
  assign flush = !enabled || (active_mode && !active_q_ff) || (auto_sleep != sleep_q_ff);

  // push qualification
  // one push per output-rate tick
  assign push = sample_valid && enabled && !flush;
  assign pre_lim = (mode_ff == SFIFO_TRIG) && !trig_ff && (cnt_ff >= wmrk_ff);
  assign post_done = (post_cnt_ff == (`SFIFO_DEPTH - wmrk_ff));
  assign write_en = push
    && !((mode_ff == SFIFO_FILL) && full)
    && !((mode_ff == SFIFO_TRIG) && !trig_ff && (wmrk_ff == 6'h00))
    && !((mode_ff == SFIFO_TRIG) && trig_ff && post_done);
  assign drop = write_en && (full || pre_lim) && !pop;
  assign rd_adv = pop || drop;
  assign ovf_evt = push && full && ((mode_ff == SFIFO_CIRC) || (mode_ff == SFIFO_FILL));

  always_ff @(posedge ref_clk) begin
    if (write_en) begin
      mem_ff[wr_ptr_ff] <= {sample_x, sample_y, sample_z};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= 42'h0;
    end else if (sample_valid) begin
      cur_ff <= {sample_x, sample_y, sample_z};
    end
  end

  // pointers and count
  // count range and clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= 5'h00;
      rd_ptr_ff <= 5'h00;
      cnt_ff <= 6'h00;
    end else if (flush) begin
      wr_ptr_ff <= 5'h00;
      rd_ptr_ff <= 5'h00;
      cnt_ff <= 6'h00;
    end else begin
      if (write_en) begin
        wr_ptr_ff <= wr_ptr_ff + 5'h01;
      end
      if (rd_adv) begin
        rd_ptr_ff <= rd_ptr_ff + 5'h01;
      end
      if (write_en && !rd_adv) begin
        cnt_ff <= cnt_ff + 6'h01;
      end else if (!write_en && rd_adv) begin
        cnt_ff <= cnt_ff - 6'h01;
      end
    end
  end

  // trigger tracking
  // post-trigger sample budget
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_ff <= 1'b0;
      post_cnt_ff <= 6'h00;
    end else if (flush) begin
      trig_ff <= 1'b0;
      post_cnt_ff <= 6'h00;
    end else begin
      if ((mode_ff == SFIFO_TRIG) && trigger_event) begin
        trig_ff <= 1'b1;
      end
      if (trig_ff && write_en) begin
        post_cnt_ff <= post_cnt_ff + 6'h01;
      end
    end
  end

  assign nxt_wm = (mode_ff == SFIFO_TRIG) ? trig_ff
    : ((wmrk_ff != 6'h00) && (cnt_ff >= wmrk_ff));

  // flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_ff <= 1'b0;
      wm_ff <= 1'b0;
    end else if (flush) begin
      ovf_ff <= 1'b0;
      wm_ff <= 1'b0;
    end else begin
      wm_ff <= nxt_wm;
      if (mode_ff == SFIFO_TRIG) begin
        ovf_ff <= trig_ff && post_done;
      end else if (ovf_evt) begin
        ovf_ff <= 1'b1;
      end else if (!full) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // interrupt source bit, set beats the clearing read
  // clear on status read, re-arm on sample
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      flag_q_ff <= ovf_ff || wm_ff;
      if (((ovf_ff || wm_ff) && !flag_q_ff) || (write_en && (ovf_ff || wm_ff))) begin
        irq_ff <= 1'b1;
      end else if (status_rd || flush) begin
        irq_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gclr_ff <= 1'b0;
    end else begin
      gclr_ff <= pop && !write_en && (cnt_ff == 6'h01);
    end
  end

  assign lk_ack = lk_ack_ff;
  assign lk_rdata = lk_rdata_ff;
  assign buffer_irq_status = irq_ff;
  assign gate_error_clear = gclr_ff;

  // checks
  property p_status_map;
    @(posedge ref_clk) disable iff (!rst_n)
    status_rd |=> (rd_ref_ff == $past({ovf_ff, wm_ff, cnt_ff}));
  endproperty
  a_status_map: assert property (p_status_map) else $error("status read mismatch");

  property p_cnt_range;
    @(posedge ref_clk) disable iff (!rst_n)
    cnt_ff <= `SFIFO_DEPTH;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("count above depth");

  property p_ovf_set;
    @(posedge ref_clk) disable iff (!rst_n)
    ovf_evt && !flush |=> ovf_ff;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");

  property p_wm_level;
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_ff != SFIFO_TRIG) && !flush && (wmrk_ff != 6'h00) && (cnt_ff >= wmrk_ff) |=> wm_ff;
  endproperty
  a_wm_level: assert property (p_wm_level) else $error("watermark flag missing");

  property p_wm_off;
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_ff != SFIFO_TRIG) && (wmrk_ff == 6'h00) ##1 (wmrk_ff == 6'h00) |-> !wm_ff;
  endproperty
  a_wm_off: assert property (p_wm_off) else $error("watermark flag with zero level");

  property p_irq_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    status_rd && !write_en && !((ovf_ff || wm_ff) && !flag_q_ff) |=> !buffer_irq_status;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq bit not cleared");

  property p_disable_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_ff == SFIFO_OFF) |=> (cnt_ff == 6'h00) && !ovf_ff && !wm_ff;
  endproperty
  a_disable_clear: assert property (p_disable_clear) else $error("disable did not clear");

  property p_circ_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_ff == SFIFO_CIRC) && push && full && !pop |=> full ##0 ovf_ff;
  endproperty
  a_circ_hold: assert property (p_circ_hold) else $error("circular overflow wrong");

  property p_fill_stop;
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_ff == SFIFO_FILL) && full && push |=> $stable(wr_ptr_ff);
  endproperty
  a_fill_stop: assert property (p_fill_stop) else $error("fill mode accepted sample");

  property p_trig_ovf;
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_ff == SFIFO_TRIG) && !trig_ff |=> !ovf_ff;
  endproperty
  a_trig_ovf: assert property (p_trig_ovf) else $error("overflow before trigger");

  property p_flush_active;
    @(posedge ref_clk) disable iff (!rst_n)
    active_mode && !active_q_ff |=> (cnt_ff == 6'h00);
  endproperty
  a_flush_active: assert property (p_flush_active) else $error("no flush on activation");

  property p_pop_dec;
    @(posedge ref_clk) disable iff (!rst_n)
    pop && !write_en && !flush |=> (cnt_ff == $past(cnt_ff) - 6'h01);
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop did not decrement");

endmodule // sfifo_top
